// *** hw/ccr_top.sv ***
// Clock and reset generator: fast/slow system clock enables, aux pins, reset
`timescale 1ns/100ps
module ccr_top #(
    parameter int DIV_W       = 16,                      // Divisor width
    parameter int NUM_MOD_RST = 4,                       // On-chip reset requesters
    parameter int NUM_AUX     = 2,                       // Divided clock pins
    parameter int POR_CYCLES  = ccr_pkg::POR_CYCLES      // Power-on stretch
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   ref_tick,
    input  wire logic                   pll_tick,
    input  wire logic                   pll_locked,
    input  wire logic [3:0]             pll_mult_req,
    input  wire logic [DIV_W-1:0]       pll_presc,
    input  wire logic                   sel_pll,
    input  wire logic                   slow_xtal_fitted,
    input  wire logic                   slow_xtal_tick,
    input  wire logic                   power_save,
    input  wire logic [DIV_W-1:0]       fix_div,
    input  wire logic [DIV_W*NUM_AUX-1:0] aux_div,
    input  wire logic                   ext_rst_n,
    input  wire logic [NUM_MOD_RST-1:0] mod_rst_req,
    output      logic                   pll_ref_en,
    output      logic [3:0]             pll_mult,
    output      logic                   hs_clk_en,
    output      logic                   slow_clk_en,
    output      logic                   sys_clk_en,
    output      logic                   twm_clk_en,
    output      logic                   fix_clk_en,
    output      logic [NUM_AUX-1:0]     aux_clk_out,
    output      logic                   por_busy,
    output      logic                   sys_rst_n
);

    // Elaboration checks
    if (DIV_W < 9) begin : g_bad_div
        $error("ccr_top: DIV_W too narrow for the slow prescaler");
    end
    if (NUM_AUX < 1 || NUM_MOD_RST < 1) begin : g_bad_cnt
        $error("ccr_top: NUM_AUX and NUM_MOD_RST must be at least 1");
    end
    if (POR_CYCLES < 1 || POR_CYCLES > 65535) begin : g_bad_por
        $error("ccr_top: POR_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Loop reference and multiplier limit
    logic [3:0] mult_ff;               // Factor sent to the loop
    logic [3:0] nxt_mult;

    // The reference feeds the loop unchanged
    assign pll_ref_en = ref_tick;

    // Clamp the requested factor so the loop never exceeds the top rate
    always_comb begin
        if (pll_mult_req > 4'(ccr_pkg::PLL_MAX_MULT)) begin
            nxt_mult = 4'(ccr_pkg::PLL_MAX_MULT);
        end else if (pll_mult_req == 4'h0) begin
            nxt_mult = 4'h1;                                        // Zero means unity
        end else begin
            nxt_mult = pll_mult_req;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mult_ff <= 4'h1;
        end else begin
            mult_ff <= nxt_mult;
        end
    end

    assign pll_mult = mult_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Prescalers
    logic               pll_div_tick;  // Prescaled loop output
    logic               slow_div_tick; // Slow clock made from the reference
    logic [NUM_AUX-1:0] aux_tick;      // Per-pin half-period pulses

    // Loop output through its prescaler
    ccr_div #(.DIV_W(DIV_W)) u_pll_div (
        .clk      (clk),
        .rstn     (rstn),
        .tick_in  (pll_tick),
        .div      (pll_presc),
        .tick_out (pll_div_tick)
    );

    // Slow clock prescaler, used when no slow crystal is fitted
    ccr_div #(.DIV_W(DIV_W)) u_slow_div (
        .clk      (clk),
        .rstn     (rstn),
        .tick_in  (ref_tick),
        .div      (DIV_W'(ccr_pkg::SLOW_PRESC_DIV)),
        .tick_out (slow_div_tick)
    );

    // Fixed-rate module clock, independent of the loop setting
    ccr_div #(.DIV_W(DIV_W)) u_fix_div (
        .clk      (clk),
        .rstn     (rstn),
        .tick_in  (ref_tick),
        .div      (fix_div),
        .tick_out (fix_clk_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Fast clock source switch
    ccr_pkg::ccr_src_type st_ff;       // Current source state
    ccr_pkg::ccr_src_type nxt_st;
    logic                 want_pll;    // Loop requested and usable

    assign want_pll = sel_pll && pll_locked;

    // Hand over only on a pulse of the new source so no period is cut short
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ccr_pkg::CCR_ST_DIRECT: begin
                if (want_pll) begin
                    nxt_st = ccr_pkg::CCR_ST_TO_PLL;
                end
            end
            ccr_pkg::CCR_ST_TO_PLL: begin
                if (!want_pll) begin
                    nxt_st = ccr_pkg::CCR_ST_TO_DIR;
                end else if (pll_div_tick) begin
                    nxt_st = ccr_pkg::CCR_ST_PLL;
                end
            end
            ccr_pkg::CCR_ST_PLL: begin
                // Losing lock falls back without waiting for software
                if (!want_pll) begin
                    nxt_st = ccr_pkg::CCR_ST_TO_DIR;
                end
            end
            ccr_pkg::CCR_ST_TO_DIR: begin
                if (ref_tick) begin
                    nxt_st = ccr_pkg::CCR_ST_DIRECT;
                end
            end
            default: begin
                nxt_st = ccr_pkg::CCR_ST_DIRECT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= ccr_pkg::CCR_ST_DIRECT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Gated pulse: waiting states pass only the pulse that completes the switch
    always_comb begin
        case (st_ff)
            ccr_pkg::CCR_ST_DIRECT: hs_clk_en = ref_tick;
            ccr_pkg::CCR_ST_TO_PLL: hs_clk_en = want_pll && pll_div_tick;
            ccr_pkg::CCR_ST_PLL:    hs_clk_en = want_pll && pll_div_tick;
            ccr_pkg::CCR_ST_TO_DIR: hs_clk_en = ref_tick;
            default:                hs_clk_en = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slow clock and system clock selection
    assign slow_clk_en = slow_xtal_fitted ? slow_xtal_tick : slow_div_tick;
    assign sys_clk_en  = power_save ? slow_clk_en : hs_clk_en;
    assign twm_clk_en  = slow_clk_en;

    ////////////////////////////////////////////////////////////////////////////
    // Divided clock pins, each toggling on its own prescaled fast pulse
    logic [NUM_AUX-1:0] aux_ff;        // Pin levels
    logic [NUM_AUX-1:0] nxt_aux;

    for (genvar i = 0; i < NUM_AUX; i++) begin : g_aux
        ccr_div #(.DIV_W(DIV_W)) u_aux_div (
            .clk      (clk),
            .rstn     (rstn),
            .tick_in  (hs_clk_en),
            .div      (aux_div[i*DIV_W +: DIV_W]),
            .tick_out (aux_tick[i])
        );
        assign nxt_aux[i] = aux_ff[i] ^ aux_tick[i];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aux_ff <= '0;
        end else begin
            aux_ff <= nxt_aux;
        end
    end

    assign aux_clk_out = aux_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Power-on reset stretch; rstn stands for the supply detector
    logic [15:0] por_cnt_ff;           // Cycles since supply came up
    logic [15:0] nxt_por_cnt;
    logic        por_ff;               // Stretch still running
    logic        nxt_por;

    always_comb begin
        nxt_por_cnt = por_cnt_ff;
        nxt_por     = por_ff;
        if (por_ff) begin
            if (por_cnt_ff == 16'(POR_CYCLES - 1)) begin
                nxt_por = 1'b0;
            end else begin
                nxt_por_cnt = por_cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            por_cnt_ff <= 16'h0000;
            por_ff     <= 1'b1;
        end else begin
            por_cnt_ff <= nxt_por_cnt;
            por_ff     <= nxt_por;
        end
    end

    assign por_busy = por_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Combined reset: any source clears the chain at once, release is clocked
    logic       arst_n;                // Combined asynchronous reset
    logic [1:0] rst_sync_ff;           // Release synchroniser
    logic [1:0] nxt_rst_sync;

    assign arst_n       = rstn && ext_rst_n && !(|mod_rst_req);
    assign nxt_rst_sync = {rst_sync_ff[0], !por_ff};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= nxt_rst_sync;
        end
    end

    assign sys_rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    rst_req_assert_a: assert property (@(posedge clk) disable iff (!rstn)
        (!ext_rst_n || (|mod_rst_req)) |-> !sys_rst_n)
        else $error("reset request did not hold system reset");
    rst_release_sync_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(sys_rst_n) |-> $past(arst_n, 1) && $past(arst_n, 2)
                             && !$past(por_ff, 2))
        else $error("reset released without two clean cycles");
    por_holds_rst_a: assert property (@(posedge clk) disable iff (!rstn)
        por_busy |-> !sys_rst_n)
        else $error("system reset released during power-on stretch");
    switch_no_runt_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_ff == ccr_pkg::CCR_ST_TO_PLL && want_pll && pll_div_tick)
        |-> hs_clk_en ##1 (st_ff == ccr_pkg::CCR_ST_PLL))
        else $error("switch to loop not completed on its pulse");
    hs_source_a: assert property (@(posedge clk) disable iff (!rstn)
        hs_clk_en |-> (ref_tick && st_ff != ccr_pkg::CCR_ST_PLL
                       && st_ff != ccr_pkg::CCR_ST_TO_PLL)
                      || (pll_div_tick && want_pll))
        else $error("fast clock pulse from wrong source");
    lock_loss_a: assert property (@(posedge clk) disable iff (!rstn)
        (st_ff == ccr_pkg::CCR_ST_PLL && !pll_locked)
        |=> st_ff == ccr_pkg::CCR_ST_TO_DIR)
        else $error("loop kept after lock loss");
    mult_limit_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 pll_mult <= 4'(ccr_pkg::PLL_MAX_MULT) && pll_mult != 4'h0)
        else $error("loop factor above limit");
    // A prescaled slow pulse must follow a reference pulse by one cycle
    slow_select_a: assert property (@(posedge clk) disable iff (!rstn)
        slow_clk_en |-> (slow_xtal_fitted ? slow_xtal_tick : $past(ref_tick)))
        else $error("slow clock from wrong source");
    save_clock_a: assert property (@(posedge clk) disable iff (!rstn)
        power_save |-> (sys_clk_en == slow_clk_en) && (twm_clk_en == slow_clk_en))
        else $error("power save not on slow clock");
    fix_from_ref_a: assert property (@(posedge clk) disable iff (!rstn)
        fix_clk_en |-> $past(ref_tick))
        else $error("fixed clock pulse without reference pulse");
    aux_toggle_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(aux_clk_out[0]) |-> $past(aux_tick[0]))
        else $error("aux pin toggled without divider pulse");
    cov_to_pll_c: cover property (@(posedge clk) disable iff (!rstn)
        st_ff == ccr_pkg::CCR_ST_TO_PLL ##[1:50] st_ff == ccr_pkg::CCR_ST_PLL);
    cov_back_dir_c: cover property (@(posedge clk) disable iff (!rstn)
        st_ff == ccr_pkg::CCR_ST_TO_DIR ##[1:50] st_ff == ccr_pkg::CCR_ST_DIRECT);
    cov_save_c: cover property (@(posedge clk) disable iff (!rstn)
        power_save && sys_clk_en);
    cov_mod_rst_c: cover property (@(posedge clk) disable iff (!rstn)
        sys_rst_n ##1 (|mod_rst_req));

endmodule : ccr_top

// *** hw/ccr_pkg.sv ***
// Constants, timing counts and state type of the clock and reset generator
package ccr_pkg;

    // Clock rates in hertz, clk period in nanoseconds
    localparam int REF_FREQ_HZ    = 12_000_000;    // Main crystal reference
    localparam int SYS_MAX_HZ     = 24_000_000;    // Highest fast system clock
    localparam int SLOW_FREQ_HZ   = 32_768;        // Slow system clock
    localparam int CLK_PERIOD_NS  = 100;           // Period of clk (10 MHz)

    // Derived dividers and multiplier limit
    localparam int SLOW_PRESC_DIV = REF_FREQ_HZ / SLOW_FREQ_HZ;   // 366, rate is approximate
    localparam int PLL_MAX_MULT   = SYS_MAX_HZ / REF_FREQ_HZ;     // Loop factor ceiling
    localparam int FIX_DIV_RESET  = 12;                           // Fixed module clock divisor

    // Power-on reset stretch, least time rounded up to whole cycles
    localparam int POR_TIME_NS    = 100_000;
    localparam int POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset values of programmable settings
    localparam int PLL_PRESC_RESET = 1;            // Loop output prescaler
    localparam int AUX_DIV_RESET   = 2;            // Aux pin divisors

    // Source switch states, one-hot
    typedef enum logic [3:0] {
        CCR_ST_DIRECT = 4'h1,                      // Reference drives fast clock
        CCR_ST_TO_PLL = 4'h2,                      // Waiting for loop pulse
        CCR_ST_PLL    = 4'h4,                      // Prescaled loop drives fast clock
        CCR_ST_TO_DIR = 4'h8                       // Waiting for reference pulse
    } ccr_src_type;

endpackage : ccr_pkg

// *** hw/ccr_div.sv ***
// Pulse divider: one output pulse for every div input pulses
`timescale 1ns/100ps
module ccr_div #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             tick_in,
    input  wire logic [DIV_W-1:0] div,
    output      logic             tick_out
);

    logic [DIV_W-1:0] cnt_ff;          // Input pulses seen in this period
    logic [DIV_W-1:0] nxt_cnt;
    logic             tick_ff;         // Registered output pulse
    logic             nxt_tick;
    logic [DIV_W-1:0] last;            // Terminal count

    if (DIV_W < 2) begin : g_bad_width
        $error("ccr_div: DIV_W must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next count; a divisor of zero acts as one so the output never stops
    always_comb begin
        last     = (div == '0) ? '0 : div - DIV_W'(1);
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (tick_in) begin
            // A divisor lowered below the count wraps at once, no long period
            if (cnt_ff >= last) begin
                nxt_cnt  = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt  = cnt_ff + DIV_W'(1);
            end
        end
    end

    // Register stage only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_out = tick_ff;

endmodule : ccr_div

// *** tb/ccr_osc_model.sv ***
// Behavioural crystal, loop and slow crystal sources feeding the clock generator
`timescale 1ns/100ps
module ccr_osc_model #(
    parameter int REF_PER  = 2,                 // Cycles between reference edges
    parameter int PLL_PER  = 1,                 // Cycles between loop edges
    parameter int SLOW_PER = 7                  // Cycles between slow crystal edges
) (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      ref_tick,
    output logic      pll_tick,
    output logic      slow_xtal_tick
);
    int ref_cnt;                                // Reference phase
    int pll_cnt;                                // Loop phase
    int slow_cnt;                               // Slow crystal phase

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillators run free, so edges keep coming outside reset; changed on the
    // falling edge to stay clear of the sampling edge
    always @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_cnt = 0;
            pll_cnt = 0;
            slow_cnt = 0;
            ref_tick <= 1'b0;
            pll_tick <= 1'b0;
            slow_xtal_tick <= 1'b0;
        end else begin
            ref_cnt = (ref_cnt + 1) % REF_PER;
            pll_cnt = (pll_cnt + 1) % PLL_PER;
            slow_cnt = (slow_cnt + 1) % SLOW_PER;
            ref_tick <= (ref_cnt == 0);
            pll_tick <= (pll_cnt == 0);
            slow_xtal_tick <= (slow_cnt == 0);
        end
    end
endmodule : ccr_osc_model

// *** tb/tb_top.sv ***
// Self-checking bench of the clock and reset generator
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
    localparam int POR = 8;                     // Short power-on stretch
    localparam int REF = 2;                     // Reference period in cycles
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ref_tick, pll_tick, slow_xtal_tick;
    logic        pll_locked = 1'b0;
    logic [3:0]  pll_mult_req = 4'h1;
    logic [15:0] pll_presc = 16'h3;
    logic        sel_pll = 1'b0;
    logic        slow_xtal_fitted = 1'b1;
    logic        power_save = 1'b0;
    logic [15:0] fix_div = 16'h5;
    logic [31:0] aux_div = {16'h3, 16'h2};
    logic        ext_rst_n = 1'b1;
    logic [3:0]  mod_rst_req = 4'h0;
    logic        pll_ref_en, hs_clk_en, slow_clk_en, sys_clk_en, twm_clk_en, fix_clk_en;
    logic [3:0]  pll_mult;
    logic [1:0]  aux_clk_out, aux_cur, aux_prv;
    logic        por_busy, sys_rst_n;
    logic [4:0]  sig;                           // Pulses watched by the interval task
    int          num_errors = 0;
    int          compares = 0;
    int          cycles = 0;

    assign sig = {hs_clk_en, aux_cur[1] ^ aux_prv[1], aux_cur[0] ^ aux_prv[0],
                  fix_clk_en, slow_clk_en};

    always #50 clk = ~clk;

    ccr_osc_model #(.REF_PER(REF), .PLL_PER(1), .SLOW_PER(7)) osc (
        .clk(clk), .rstn(rstn), .ref_tick(ref_tick), .pll_tick(pll_tick),
        .slow_xtal_tick(slow_xtal_tick));

    ccr_top #(.POR_CYCLES(POR)) dut (
        .clk(clk), .rstn(rstn), .ref_tick(ref_tick), .pll_tick(pll_tick),
        .pll_locked(pll_locked), .pll_mult_req(pll_mult_req), .pll_presc(pll_presc),
        .sel_pll(sel_pll), .slow_xtal_fitted(slow_xtal_fitted),
        .slow_xtal_tick(slow_xtal_tick), .power_save(power_save), .fix_div(fix_div),
        .aux_div(aux_div), .ext_rst_n(ext_rst_n), .mod_rst_req(mod_rst_req),
        .pll_ref_en(pll_ref_en), .pll_mult(pll_mult), .hs_clk_en(hs_clk_en),
        .slow_clk_en(slow_clk_en), .sys_clk_en(sys_clk_en), .twm_clk_en(twm_clk_en),
        .fix_clk_en(fix_clk_en), .aux_clk_out(aux_clk_out), .por_busy(por_busy),
        .sys_rst_n(sys_rst_n));

    ////////////////////////////////////////////////////////////////////////////////
    // Sample late in the cycle, after falling-edge drives and register updates
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #90;
            aux_prv = aux_cur;
            aux_cur = aux_clk_out;
        end
    endtask : step

    // Cycles between two successive pulses; bounded so a dead divider cannot hang
    task automatic interval(input int s, output int n);
        int k;
        k = 0;
        while (sig[s] !== 1'b1 && k < 2000) begin step(1); k++; end
        n = 0;
        do begin step(1); n++; end while (sig[s] !== 1'b1 && n < 2000);
    endtask : interval

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    // Power-on stretch holds the device reset after supply comes up
    task automatic t_por;
        step(POR - 1);
        `CHK("por_busy in stretch", 1'b1, por_busy)
        step(1);
        `CHK("sys_rst_n in stretch", 1'b0, sys_rst_n)
        `CHK("por_busy after", 1'b0, por_busy)
        step(1);
        `CHK("sys_rst_n sync edge1", 1'b0, sys_rst_n)
        step(1);
        `CHK("sys_rst_n after", 1'b1, sys_rst_n)
        $display("t_por done");
    endtask : t_por

    // Each module request and the external reset assert at once and release on the second edge
    task automatic t_rst_src;
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            if (i < 4) mod_rst_req[i] = 1'b1; else ext_rst_n = 1'b0;
            #1;
            `CHK("sys_rst_n async", 1'b0, sys_rst_n)
            @(negedge clk);
            mod_rst_req = 4'h0;
            ext_rst_n = 1'b1;
            step(1);
            `CHK("sys_rst_n edge1", 1'b0, sys_rst_n)
            step(1);
            `CHK("sys_rst_n edge2", 1'b1, sys_rst_n)
        end
        $display("t_rst_src done");
    endtask : t_rst_src

    // Direct source: fast clock and loop reference follow the reference edge
    task automatic t_direct;
        int n;
        for (int i = 0; i < 8; i++) begin
            step(1);
            `CHK("hs direct", ref_tick, hs_clk_en)
            `CHK("loop ref", ref_tick, pll_ref_en)
        end
        interval(4, n);
        `CHK("hs period direct", REF, n)
        interval(1, n);
        `CHK("fix period", 5 * REF, n)
        interval(2, n);
        `CHK("aux0 toggle", 2 * REF, n)
        interval(3, n);
        `CHK("aux1 toggle", 3 * REF, n)
        $display("t_direct done");
    endtask : t_direct

    // Loop source through prescaler, fixed clock unaffected, lock loss falls back
    task automatic t_loop;
        int n;
        @(negedge clk);
        sel_pll = 1'b1;
        pll_locked = 1'b1;
        step(20);
        interval(4, n);
        `CHK("hs period loop", 3, n)
        interval(1, n);
        `CHK("fix period loop", 5 * REF, n)
        @(negedge clk);
        pll_locked = 1'b0;
        step(10);
        interval(4, n);
        `CHK("hs after lock loss", REF, n)
        @(negedge clk);
        sel_pll = 1'b0;
        $display("t_loop done");
    endtask : t_loop

    // Loop factor limited to the 12 to 24 MHz range
    task automatic t_mult;
        logic [3:0] req [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
        logic [3:0] exp [4] = '{4'h1, 4'h1, 4'h2, 4'h2};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            pll_mult_req = req[i];
            step(2);
            `CHK("pll_mult", exp[i], pll_mult)
        end
        $display("t_mult done");
    endtask : t_mult

    // Slow clock from crystal or prescaler, drives watchdog and power-save clock
    task automatic t_slow;
        int n;
        @(negedge clk);
        power_save = 1'b1;
        for (int i = 0; i < 16; i++) begin
            step(1);
            `CHK("slow from xtal", slow_xtal_tick, slow_clk_en)
            `CHK("twm clock", slow_xtal_tick, twm_clk_en)
            `CHK("sys in power save", slow_xtal_tick, sys_clk_en)
        end
        @(negedge clk);
        slow_xtal_fitted = 1'b0;
        interval(0, n);
        interval(0, n);
        `CHK("slow prescaled", ccr_pkg::SLOW_PRESC_DIV * REF, n)
        @(negedge clk);
        power_save = 1'b0;
        step(1);
        `CHK("sys active", ref_tick, sys_clk_en)
        $display("t_slow done");
    endtask : t_slow

    // Hang guard: well above the roughly 2200 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        aux_cur = 2'h0;
        aux_prv = 2'h0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_por();
        t_rst_src();
        t_direct();
        t_loop();
        t_mult();
        t_slow();
        stop_test();
    end
endmodule : tb_top
